// ===== panel_monitor_regs.svh
// Constants for the panel monitor value selector.
// Assumes inclusion by the selector module only.
`ifndef PANEL_MONITOR_REGS_SVH
`define PANEL_MONITOR_REGS_SVH
`define SEL_MAX 5'h10
`define SEL_RESET 5'h01
`define SCALE_MIN 15'h0001
`define SCALE_MAX 15'h7530
`define SCALE_RESET 15'h0bb8
`define FILT_MAX 4'hd
`define FILT_RESET 4'h6
`define PRESS_MAX 7'h64
`define PRESS_RESET 7'h14
`define CYCLE_MAX 4'h9
`define REFRESH_NS 10000000
`define CLK_NS 10
`define REFRESH_CYC (`REFRESH_NS / `CLK_NS)
`endif

// ===== panel_monitor_pkg.sv
// Types for the panel monitor value selector.
// Constants live in panel_monitor_regs.svh.
package panel_monitor_pkg;
  typedef enum logic [4:0] {
    sel_freq_cmd = 5'h00, sel_freq_out = 5'h01, sel_current = 5'h02,
    sel_voltage = 5'h03, sel_unitless = 5'h04, sel_bus_run = 5'h05,
    sel_bus_start = 5'h06, sel_pot = 5'h07, sel_ain1 = 5'h08,
    sel_ain2 = 5'h09, sel_pid = 5'h0a, sel_din = 5'h0b,
    sel_pressure = 5'h0c, sel_auto = 5'h0d, sel_version = 5'h0e
  } monitor_sel_e;
  typedef enum logic [1:0] {
    st_idle = 2'b00, st_filter = 2'b01, st_show = 2'b11
  } disp_state_e;
  typedef struct packed {
    logic [15:0] freq_cmd;
    logic [15:0] freq_out;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] bus_run;
    logic [15:0] bus_start;
    logic [15:0] pot_pct;
    logic [15:0] ain1_pct;
    logic [15:0] ain2_pct;
    logic [15:0] pid_pct;
    logic [7:0] din;
    logic [6:0] pressure_now;
    logic [3:0] auto_cycle;
    logic [3:0] auto_stage;
    logic [15:0] version;
  } sources_s;
  typedef struct packed {
    logic [4:0] sel;
    logic [14:0] scale;
    logic [3:0] filt;
    logic [6:0] press_tgt;
  } params_s;
  typedef struct packed {
    logic [31:0] value;
    logic [7:0] glyph;
    logic valid;
    logic split;
  } display_s;
endpackage : panel_monitor_pkg

// ===== panel_monitor_value_selector.sv
// Panel monitor value selector: picks, scales and filters one quantity.
// Sources and parameters are on the core clock; din is a pin, synchronised.
// Function
// - Selector 0..16, resets to output frequency
// - Codes 0..3: set freq, out freq, current, voltage
// - Code 4 shows frequency times scaling factor
// - Scale 0.01..300.00, default 30.00, live change
// - Codes 5,6: running and pre-start bus voltage
// - Codes 7..9: pot, analog inputs as percent
// - Code 10: PID output percent
// - Code 11: digital input image, live only with filter 0
// - Code 12: pressure target and actual side by side
// - Code 13: cycle digit 0..9 and stage
// - Stage as hex glyph 0123456789AbcdEF
// - Code 14 version; 15,16 show nothing
// - Low-pass filter 0..13, default 6
// - Pressure target 0.0..10.0, default 2.0
`timescale 1ns/1ps
`include "panel_monitor_regs.svh"
module panel_monitor_value_selector
  import panel_monitor_pkg::*;
#(
  parameter int REFRESH_CYCLES = `REFRESH_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Parameter writes
  input wire logic param_we_i,
  input wire params_s param_wdata_i,
  // Running quantities
  input wire sources_s sources_i,
  input wire logic running_i,
  // Panel side
  output params_s params_o,
  output display_s display_o
);
  typedef struct packed {
    params_s prm;
    logic [4:0] shown_sel;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic [7:0] din_s3;
    logic [7:0] din_q;
    logic [15:0] bus_start;
    logic [31:0] raw;
    logic [31:0] filt_acc;
    logic [31:0] tick;
    logic refresh;
    disp_state_e st;
    display_s disp;
  } state_s;

  state_s q;
  state_s d;

  // Hex glyph codes, segments gfedcba
  function automatic logic [7:0] stage_glyph(input logic [3:0] v);
    case (v)
      4'h0: stage_glyph = 8'h3f;
      4'h1: stage_glyph = 8'h06;
      4'h2: stage_glyph = 8'h5b;
      4'h3: stage_glyph = 8'h4f;
      4'h4: stage_glyph = 8'h66;
      4'h5: stage_glyph = 8'h6d;
      4'h6: stage_glyph = 8'h7d;
      4'h7: stage_glyph = 8'h07;
      4'h8: stage_glyph = 8'h7f;
      4'h9: stage_glyph = 8'h6f;
      4'ha: stage_glyph = 8'h77;
      4'hb: stage_glyph = 8'h7c;
      4'hc: stage_glyph = 8'h58;
      4'hd: stage_glyph = 8'h5e;
      4'he: stage_glyph = 8'h79;
      default: stage_glyph = 8'h71;
    endcase
  endfunction : stage_glyph

  // Parameter range check, shared by write path
  function automatic logic params_ok(input params_s p);
    params_ok = (p.sel <= `SEL_MAX) && (p.scale >= `SCALE_MIN) &&
      (p.scale <= `SCALE_MAX) && (p.filt <= `FILT_MAX) &&
      (p.press_tgt <= `PRESS_MAX);
  endfunction : params_ok

  logic [31:0] scaled;
  assign scaled = 32'(q.prm.scale) * 32'(sources_i.freq_cmd);

  always_comb begin
    d = q;
    d.din_s1 = sources_i.din;
    d.din_s2 = q.din_s1;
    d.din_s3 = q.din_s2;
    if (q.din_s2 == q.din_s3) begin
      d.din_q = q.din_s3;
    end
    // Writes out of range are ignored; scale accepted while running
    if (param_we_i && params_ok(param_wdata_i)) begin
      d.prm = param_wdata_i;
    end
    if (!running_i) begin
      d.bus_start = sources_i.bus_run;
    end
    d.refresh = 1'b0;
    if (q.tick == 32'(REFRESH_CYCLES - 1)) begin
      d.tick = '0;
      d.refresh = 1'b1;
    end else begin
      d.tick = q.tick + 32'h1;
    end
    d.disp.glyph = 8'h00;
    d.disp.split = 1'b0;
    d.disp.valid = 1'b1;
    case (q.prm.sel)
      5'h00: d.raw = 32'(sources_i.freq_cmd);
      5'h01: d.raw = 32'(sources_i.freq_out);
      5'h02: d.raw = 32'(sources_i.current);
      5'h03: d.raw = 32'(sources_i.voltage);
      5'h04: d.raw = scaled;
      5'h05: d.raw = 32'(sources_i.bus_run);
      5'h06: d.raw = 32'(q.bus_start);
      5'h07: d.raw = 32'(sources_i.pot_pct);
      5'h08: d.raw = 32'(sources_i.ain1_pct);
      5'h09: d.raw = 32'(sources_i.ain2_pct);
      5'h0a: d.raw = 32'(sources_i.pid_pct);
      5'h0b: d.raw = 32'(q.din_q);
      5'h0c: begin
        d.raw = {9'h000, q.prm.press_tgt, 9'h000, sources_i.pressure_now};
        d.disp.split = 1'b1;
      end
      5'h0d: begin
        d.raw = (sources_i.auto_cycle > `CYCLE_MAX) ? 32'(`CYCLE_MAX) :
          32'(sources_i.auto_cycle);
        d.disp.glyph = stage_glyph(sources_i.auto_stage);
      end
      5'h0e: d.raw = 32'(sources_i.version);
      default: begin
        d.raw = '0;
        d.disp.valid = 1'b0;
      end
    endcase
    case (q.st)
      st_idle: begin
        if (q.refresh) begin
          d.st = st_filter;
        end
      end
      st_filter: begin
        // Split or unfiltered views bypass smoothing
        // Registered raw may still hold the old code's value; use this cycle's
        if (q.shown_sel != q.prm.sel || q.prm.filt == 4'h0 || d.disp.split) begin
          d.filt_acc = d.raw;
          d.shown_sel = q.prm.sel;
        end else begin
          d.filt_acc = q.filt_acc + ((d.raw >>> q.prm.filt) -
            (q.filt_acc >>> q.prm.filt));
        end
        d.st = st_show;
      end
      st_show: begin
        d.disp.value = q.filt_acc;
        d.st = st_idle;
      end
      default: d.st = st_idle;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.prm.sel <= `SEL_RESET;
      q.prm.scale <= `SCALE_RESET;
      q.prm.filt <= `FILT_RESET;
      q.prm.press_tgt <= `PRESS_RESET;
      q.shown_sel <= `SEL_RESET;
      q.st <= st_idle;
    end else begin
      q <= d;
    end
  end

  assign params_o = q.prm;
  assign display_o = q.disp;

  property p_sel_range;
    @(posedge core_clk_i) disable iff (rst_i) q.prm.sel <= `SEL_MAX;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selector out of range");
  property p_scale_range;
    @(posedge core_clk_i) disable iff (rst_i)
      q.prm.scale >= `SCALE_MIN && q.prm.scale <= `SCALE_MAX;
  endproperty
  a_scale_range: assert property (p_scale_range) else $error("scale out of range");
  property p_filt_range;
    @(posedge core_clk_i) disable iff (rst_i) q.prm.filt <= `FILT_MAX;
  endproperty
  a_filt_range: assert property (p_filt_range) else $error("filter out of range");
  property p_press_range;
    @(posedge core_clk_i) disable iff (rst_i) q.prm.press_tgt <= `PRESS_MAX;
  endproperty
  a_press_range: assert property (p_press_range) else $error("target out of range");
  property p_unitless;
    @(posedge core_clk_i) disable iff (rst_i)
      q.prm.sel == 5'h04 && $stable(q.prm.sel) |=> q.raw == $past(scaled);
  endproperty
  a_unitless: assert property (p_unitless) else $error("unitless value wrong");
  property p_reserved;
    @(posedge core_clk_i) disable iff (rst_i)
      q.prm.sel > 5'h0e && $stable(q.prm.sel) |=> !display_o.valid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code shown");
  property p_cycle_digit;
    @(posedge core_clk_i) disable iff (rst_i)
      q.prm.sel == 5'h0d && $stable(q.prm.sel) |=> q.raw <= 32'(`CYCLE_MAX);
  endproperty
  a_cycle_digit: assert property (p_cycle_digit) else $error("cycle above 9");
  property p_restart;
    @(posedge core_clk_i) disable iff (rst_i)
      q.st == st_filter && q.shown_sel != q.prm.sel |=> q.filt_acc == $past(d.raw);
  endproperty
  a_restart: assert property (p_restart) else $error("filter not restarted");
  property p_show;
    @(posedge core_clk_i) disable iff (rst_i)
      q.st == st_show |=> display_o.value == $past(q.filt_acc) ##1 q.st == st_idle;
  endproperty
  a_show: assert property (p_show) else $error("display not updated");
  c_pressure: cover property (@(posedge core_clk_i) display_o.split);
  c_auto: cover property (@(posedge core_clk_i) q.prm.sel == 5'h0d && q.st == st_show);
  c_change: cover property (@(posedge core_clk_i) q.st == st_filter && q.shown_sel != q.prm.sel);
endmodule : panel_monitor_value_selector

// ===== panel_display_model.sv
// Panel display model: latches what the selector presents each cycle.
// Assumes the core clock and the selector's display struct.
`timescale 1ns/1ps
module panel_display_model
  import panel_monitor_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // From selector
  input wire display_s display_i,
  // Shown state
  output display_s shown_o
);
  // Panel only refreshes from a settled register copy
  always_ff @(posedge core_clk_i) begin
    shown_o <= display_i;
  end
endmodule : panel_display_model

// ===== panel_monitor_value_selector_tb.sv
// Testbench for the panel monitor value selector.
// Assumes REFRESH_CYCLES of 8 and constant sources between checks.
`timescale 1ns/1ps
module panel_monitor_value_selector_tb;
  import panel_monitor_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic param_we_i = 1'b0;
  params_s param_wdata_i = '0;
  sources_s sources_i = '0;
  logic running_i = 1'b0;
  params_s params_o;
  display_s display_o;
  display_s shown;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  panel_monitor_value_selector #(.REFRESH_CYCLES(8)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .param_we_i(param_we_i),
    .param_wdata_i(param_wdata_i), .sources_i(sources_i), .running_i(running_i),
    .params_o(params_o), .display_o(display_o));
  panel_display_model panel (.core_clk_i(core_clk_i), .display_i(display_o), .shown_o(shown));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [4:0] s, input logic [14:0] sc, input logic [3:0] f,
                    input logic [6:0] p);
    @(posedge core_clk_i);
    param_we_i <= 1'b1;
    param_wdata_i <= '{sel: s, scale: sc, filt: f, press_tgt: p};
    @(posedge core_clk_i);
    param_we_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : wr
  // Waits 30 cycles, nearly four refresh periods, so the new code has settled
  task automatic show(input logic [4:0] s, input logic [3:0] f);
    wr(s, 15'h0bb8, f, 7'h14);
    repeat (30) @(posedge core_clk_i);
    #1;
  endtask : show
  function automatic logic [31:0] exp_of(input logic [4:0] c);
    case (c)
      5'h00: return {16'h0, sources_i.freq_cmd};
      5'h01: return {16'h0, sources_i.freq_out};
      5'h02: return {16'h0, sources_i.current};
      5'h03: return {16'h0, sources_i.voltage};
      5'h04: return 32'(sources_i.freq_cmd) * 32'h0bb8;
      5'h05: return 32'h6789;
      5'h06: return 32'h5678;
      5'h07: return {16'h0, sources_i.pot_pct};
      5'h08: return {16'h0, sources_i.ain1_pct};
      5'h09: return {16'h0, sources_i.ain2_pct};
      5'h0a: return {16'h0, sources_i.pid_pct};
      5'h0b: return {24'h0, sources_i.din};
      5'h0c: return {9'h0, 7'h14, 9'h0, 7'h2d};
      5'h0d: return 32'h9;
      default: return {16'h0, sources_i.version};
    endcase
  endfunction : exp_of
  initial begin
    sources_i <= '{freq_cmd: 16'h1234, freq_out: 16'h2345, current: 16'h3456,
      voltage: 16'h4567, bus_run: 16'h5678, bus_start: 16'h0, pot_pct: 16'h0031,
      ain1_pct: 16'h0042, ain2_pct: 16'h0053, pid_pct: 16'h0064, din: 8'ha5,
      pressure_now: 7'h2d, auto_cycle: 4'ha, auto_stage: 4'h0, version: 16'h0107};
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(32'(params_o), 32'({5'h01, 15'h0bb8, 4'h6, 7'h14}));
    $display("defaults done");
    // Out-of-range writes are dropped whole
    wr(5'h02, 15'h0000, 4'h0, 7'h14);
    chk(32'(params_o.scale), 32'h0bb8);
    wr(5'h02, 15'h7530, 4'he, 7'h14);
    chk(32'(params_o.filt), 32'h6);
    wr(5'h02, 15'h0bb8, 4'h0, 7'h65);
    chk(32'({params_o.sel, params_o.press_tgt}), 32'({5'h01, 7'h14}));
    wr(5'h10, 15'h7530, 4'hd, 7'h64);
    chk(32'({params_o.sel, params_o.scale}), 32'({5'h10, 15'h7530}));
    chk(32'(params_o.press_tgt), 32'h64);
    $display("refusal done");
    // Pre-start bus voltage kept once running
    repeat (4) @(posedge core_clk_i);
    running_i <= 1'b1;
    sources_i.bus_run <= 16'h6789;
    for (int c = 0; c <= 14; c++) begin
      show(5'(c), 4'h0);
      chk(shown.value, exp_of(5'(c)));
      chk(32'(display_o.valid), 32'h1);
      chk(32'(display_o.split), {31'h0, c == 12});
      if (c == 13) chk(32'(display_o.glyph), 32'h3f);
    end
    $display("selector table done");
    for (int c = 15; c <= 16; c++) begin
      show(5'(c), 4'h0);
      chk(32'(display_o.valid), 32'h0);
    end
    $display("reserved done");
    // Digital inputs follow live in standby too
    @(posedge core_clk_i);
    running_i <= 1'b0;
    sources_i.din <= 8'h3c;
    show(5'h0b, 4'h0);
    chk(display_o.value, 32'h3c);
    // Filter restarts from the new quantity
    show(5'h02, 4'hd);
    chk(display_o.value, 32'h3456);
    show(5'h0e, 4'h6);
    chk(display_o.value, 32'h0107);
    $display("filter restart done");
    // Truncation in the filter step leaves a one-count offset
    show(5'h07, 4'h1);
    chk(display_o.value, 32'h31);
    @(posedge core_clk_i);
    sources_i.pot_pct <= 16'h0071;
    repeat (80) @(posedge core_clk_i);
    #1;
    chk(display_o.value, 32'h70);
    $display("filter smoothing done");
    // Mid-run reset brings the defaults back
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(32'(params_o), 32'({5'h01, 15'h0bb8, 4'h6, 7'h14}));
    $display("reset done");
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge core_clk_i);
    fail_count++;
    report_and_stop();
  end
endmodule : panel_monitor_value_selector_tb
